/* File: common/prs_pkg.sv */
// Shared constants and types for the receive lane sync status block
package prs_pkg;

  // ----------------------------------------
  // Lane geometry
  // ----------------------------------------
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_IDX_W = 2;
  localparam int unsigned MARKER_W = 64;
  localparam int unsigned ERR_CNT_W = 3;

  // ----------------------------------------
  // Sync header codes; 00 and 11 are invalid headers
  // ----------------------------------------
  localparam logic [1:0] HDR_DATA = 2'h1;
  localparam logic [1:0] HDR_CTRL = 2'h2;

  // ----------------------------------------
  // Block lock and reporting counts
  // ----------------------------------------
  localparam int unsigned LOCK_GOOD = 64;
  localparam int unsigned LOSS_WINDOW = 64;
  localparam int unsigned LOSS_BAD = 16;
  localparam int unsigned REPORT_CYCLES = 8;
  localparam int unsigned MARKER_WAIT = 32768;

  localparam int unsigned GOOD_W = 7;
  localparam int unsigned WIN_W = 7;
  localparam int unsigned BAD_W = 5;
  localparam int unsigned RPT_W = 4;

  localparam logic [GOOD_W-1:0] GOOD_LAST = GOOD_W'(LOCK_GOOD - 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(LOSS_WINDOW - 1);
  localparam logic [BAD_W-1:0] BAD_LAST = BAD_W'(LOSS_BAD - 1);
  localparam logic [RPT_W-1:0] RPT_LAST = RPT_W'(REPORT_CYCLES - 1);
  localparam logic [ERR_CNT_W-1:0] ERR_MAX = '1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [1:0] hdr;
    logic [MARKER_W-1:0] data;
  } prs_blk_t;

  typedef enum logic {PRS_SEARCH, PRS_LOCKED} prs_lock_t;

endpackage

/* File: logic/prs_lane_status.sv */
// Receive lane block lock, marker demux, sync and framing error status
`timescale 1ns/100ps
module prs_lane_status #(
  parameter int unsigned MARKER_WAIT = prs_pkg::MARKER_WAIT
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire prs_pkg::prs_blk_t [prs_pkg::LANES-1:0] rx_blk_i,
  input wire logic [prs_pkg::MARKER_W-1:0] lane0_marker_value_i,
  input wire logic [prs_pkg::MARKER_W-1:0] lane1_marker_value_i,
  input wire logic [prs_pkg::MARKER_W-1:0] lane2_marker_value_i,
  input wire logic [prs_pkg::MARKER_W-1:0] lane3_marker_value_i,
  output logic [prs_pkg::LANES-1:0] block_lock_o,
  output logic [prs_pkg::LANES-1:0] framing_err_valid_o,
  output logic [prs_pkg::LANES-1:0][prs_pkg::ERR_CNT_W-1:0] framing_err_o,
  output logic [prs_pkg::LANES-1:0] lane_demux_done_o,
  output logic [prs_pkg::LANE_IDX_W-1:0] lane0_physical_source_o,
  output logic [prs_pkg::LANE_IDX_W-1:0] lane1_physical_source_o,
  output logic [prs_pkg::LANE_IDX_W-1:0] lane2_physical_source_o,
  output logic [prs_pkg::LANE_IDX_W-1:0] lane3_physical_source_o,
  output logic [prs_pkg::LANES-1:0] synced_o,
  output logic [prs_pkg::LANES-1:0] synced_err_o
);

  localparam int unsigned L = prs_pkg::LANES;
  localparam int unsigned WAIT_W = $clog2(MARKER_WAIT + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(MARKER_WAIT - 1);

  function automatic logic hdr_good(input logic [1:0] hdr);
    hdr_good = (hdr == prs_pkg::HDR_DATA) || (hdr == prs_pkg::HDR_CTRL);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  prs_pkg::prs_lock_t [L-1:0] lock_q, lock_d;
  logic [L-1:0][prs_pkg::GOOD_W-1:0] good_q, good_d;
  logic [L-1:0][prs_pkg::WIN_W-1:0] win_q, win_d;
  logic [L-1:0][prs_pkg::BAD_W-1:0] bad_q, bad_d;
  logic [L-1:0][WAIT_W-1:0] wait_q, wait_d;
  logic [L-1:0] seen_q, seen_d;
  logic [L-1:0][prs_pkg::ERR_CNT_W-1:0] acc_q, acc_d;
  logic [prs_pkg::RPT_W-1:0] rpt_q, rpt_d;
  logic [L-1:0] lock_out_q, lock_out_d;
  logic [L-1:0] fe_valid_q, fe_valid_d;
  logic [L-1:0][prs_pkg::ERR_CNT_W-1:0] fe_cnt_q, fe_cnt_d;
  logic [L-1:0] demux_q, demux_d;
  logic [L-1:0][prs_pkg::LANE_IDX_W-1:0] map_q, map_d;
  logic [L-1:0] synced_q, synced_d;
  logic [L-1:0] serr_q, serr_d;

  logic [L-1:0][prs_pkg::MARKER_W-1:0] marker;
  logic [L-1:0] bad_hdr;
  logic [L-1:0] expired;

  assign marker = {lane3_marker_value_i, lane2_marker_value_i,
                   lane1_marker_value_i, lane0_marker_value_i};

  // ----------------------------------------
  // Block lock per physical lane
  // ----------------------------------------
  always_comb begin
    lock_d = lock_q;
    good_d = good_q;
    win_d = win_q;
    bad_d = bad_q;
    for (int p = 0; p < L; p++) begin
      bad_hdr[p] = rx_blk_i[p].valid && !hdr_good(rx_blk_i[p].hdr);
      if (rx_blk_i[p].valid) begin
        unique case (lock_q[p])
          prs_pkg::PRS_SEARCH: begin
            if (bad_hdr[p]) begin
              good_d[p] = '0;
            end else if (good_q[p] == prs_pkg::GOOD_LAST) begin
              lock_d[p] = prs_pkg::PRS_LOCKED;
              good_d[p] = '0;
              win_d[p] = '0;
              bad_d[p] = '0;
            end else begin
              good_d[p] = good_q[p] + 1'b1;
            end
          end
          prs_pkg::PRS_LOCKED: begin
            if (bad_hdr[p] && bad_q[p] == prs_pkg::BAD_LAST) begin
              lock_d[p] = prs_pkg::PRS_SEARCH;
              good_d[p] = '0;
            end else if (win_q[p] == prs_pkg::WIN_LAST) begin
              win_d[p] = '0;
              bad_d[p] = '0;
            end else begin
              win_d[p] = win_q[p] + 1'b1;
              bad_d[p] = bad_q[p] + prs_pkg::BAD_W'(bad_hdr[p]);
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Marker search, demux map, sync status
  // ----------------------------------------
  always_comb begin
    demux_d = demux_q;
    map_d = map_q;
    wait_d = wait_q;
    seen_d = seen_q;
    serr_d = serr_q;
    expired = '0;
    for (int p = 0; p < L; p++) begin
      if (lock_d[p] != prs_pkg::PRS_LOCKED) begin
        wait_d[p] = '0;
        seen_d[p] = 1'b0;
      end else if (rx_blk_i[p].valid && !seen_q[p]) begin
        expired[p] = (wait_q[p] == WAIT_LAST);
        wait_d[p] = expired[p] ? '0 : wait_q[p] + 1'b1;
      end
      for (int k = 0; k < L; k++) begin
        if (demux_q[k] && map_q[k] == prs_pkg::LANE_IDX_W'(p) &&
            lock_d[p] != prs_pkg::PRS_LOCKED) begin
          demux_d[k] = 1'b0;
        end
        if (lock_q[p] == prs_pkg::PRS_LOCKED && rx_blk_i[p].valid &&
            rx_blk_i[p].hdr == prs_pkg::HDR_CTRL && rx_blk_i[p].data == marker[k] &&
            lock_d[p] == prs_pkg::PRS_LOCKED) begin
          demux_d[k] = 1'b1;
          map_d[k] = prs_pkg::LANE_IDX_W'(p);
          seen_d[p] = 1'b1;
        end
      end
    end
    for (int k = 0; k < L; k++) begin
      synced_d[k] = demux_d[k] && lock_d[map_d[k]] == prs_pkg::PRS_LOCKED;
      // Loss by framing errors or a marker that never came; set wins over clear
      // A timeout never flags a PCS lane that is synced, so sync and error stay exclusive
      if ((synced_q[k] && !synced_d[k]) || (expired[k] && !synced_d[k])) begin
        serr_d[k] = 1'b1;
      end else if (synced_d[k]) begin
        serr_d[k] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Framing error increments
  // ----------------------------------------
  // Errors are batched so a 3-bit increment carries several; a full
  // accumulator is reported early so no error is dropped.
  always_comb begin
    rpt_d = (rpt_q == prs_pkg::RPT_LAST) ? '0 : rpt_q + 1'b1;
    lock_out_d = '0;
    for (int p = 0; p < L; p++) begin
      lock_out_d[p] = (lock_d[p] == prs_pkg::PRS_LOCKED);
      if (rpt_q == prs_pkg::RPT_LAST || acc_q[p] == prs_pkg::ERR_MAX) begin
        fe_cnt_d[p] = acc_q[p];
        fe_valid_d[p] = (acc_q[p] != '0);
        acc_d[p] = prs_pkg::ERR_CNT_W'(bad_hdr[p]);
      end else begin
        fe_cnt_d[p] = '0;
        fe_valid_d[p] = 1'b0;
        acc_d[p] = acc_q[p] + prs_pkg::ERR_CNT_W'(bad_hdr[p]);
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_q <= {L{prs_pkg::PRS_SEARCH}};
      good_q <= '0;
      win_q <= '0;
      bad_q <= '0;
      wait_q <= '0;
      seen_q <= '0;
      acc_q <= '0;
      rpt_q <= '0;
      lock_out_q <= '0;
      fe_valid_q <= '0;
      fe_cnt_q <= '0;
      demux_q <= '0;
      map_q <= '0;
      synced_q <= '0;
      serr_q <= '0;
    end else begin
      lock_q <= lock_d;
      good_q <= good_d;
      win_q <= win_d;
      bad_q <= bad_d;
      wait_q <= wait_d;
      seen_q <= seen_d;
      acc_q <= acc_d;
      rpt_q <= rpt_d;
      lock_out_q <= lock_out_d;
      fe_valid_q <= fe_valid_d;
      fe_cnt_q <= fe_cnt_d;
      demux_q <= demux_d;
      map_q <= map_d;
      synced_q <= synced_d;
      serr_q <= serr_d;
    end
  end

  // Marker values are sampled every cycle; they must be held steady outside reset
  assign block_lock_o = lock_out_q;
  assign framing_err_valid_o = fe_valid_q;
  assign framing_err_o = fe_cnt_q;
  assign lane_demux_done_o = demux_q;
  assign lane0_physical_source_o = map_q[0];
  assign lane1_physical_source_o = map_q[1];
  assign lane2_physical_source_o = map_q[2];
  assign lane3_physical_source_o = map_q[3];
  assign synced_o = synced_q;
  assign synced_err_o = serr_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_last_good(int p);
    rx_blk_i[p].valid && !bad_hdr[p] && good_q[p] == prs_pkg::GOOD_LAST &&
    lock_q[p] == prs_pkg::PRS_SEARCH;
  endsequence

  sequence s_last_bad(int p);
    bad_hdr[p] && bad_q[p] == prs_pkg::BAD_LAST && lock_q[p] == prs_pkg::PRS_LOCKED;
  endsequence

  for (genvar g = 0; g < L; g++) begin : g_chk
    a_lock_gain: assert property (s_last_good(g) |=> ##1 block_lock_o[g])
      else $error("block lock not gained after last good header");
    a_lock_loss: assert property (s_last_bad(g) |=> ##1 !block_lock_o[g])
      else $error("block lock kept after too many bad headers");
    a_lock_cause: assert property ($rose(block_lock_o[g]) |-> $past(good_q[g])
      == prs_pkg::GOOD_LAST)
      else $error("block lock rose without a full good run");
    a_err_valid_cnt: assert property (framing_err_valid_o[g] |-> framing_err_o[g] != '0)
      else $error("valid framing count is zero");
    a_err_report: assert property ((rpt_q == prs_pkg::RPT_LAST && acc_q[g] != '0)
      |=> framing_err_valid_o[g] && framing_err_o[g] == $past(acc_q[g]))
      else $error("accumulated framing errors not reported");
    a_sync_demux: assert property (synced_o[g] |-> lane_demux_done_o[g] &&
      block_lock_o[map_q[g]])
      else $error("synced without demux and lock");
    a_sync_err_excl: assert property (synced_o[g] |-> !synced_err_o[g])
      else $error("synced and sync error both set");
    a_sync_loss_err: assert property ($fell(synced_o[g]) |-> synced_err_o[g])
      else $error("loss of sync not flagged");
    a_demux_map: assert property ((lock_q[g] == prs_pkg::PRS_LOCKED && rx_blk_i[g].valid
      && rx_blk_i[g].hdr == prs_pkg::HDR_CTRL && rx_blk_i[g].data == marker[0] &&
      !bad_hdr[g]) |=> lane_demux_done_o[0] &&
      lane0_physical_source_o == prs_pkg::LANE_IDX_W'(g))
      else $error("marker match not mapped to PCS lane 0");
  end

endmodule

/* File: verification/prs_far_pcs.sv */
// Far-end lane model: sends one 66-bit block per physical lane per cycle
`timescale 1ns/100ps
module prs_far_pcs (
  input wire logic clk_i,
  input wire logic [3:0][1:0] mode_i,
  input wire logic [3:0][63:0] mark_i,
  output prs_pkg::prs_blk_t [3:0] rx_blk_o
);
  // Mode per lane: 0 idle, 1 good data, 2 bad header, 3 marker
  initial rx_blk_o = '0;
  always @(posedge clk_i) begin
    for (int p = 0; p < 4; p++) begin
      rx_blk_o[p].valid <= (mode_i[p] != 2'h0);
      case (mode_i[p])
        2'h0: rx_blk_o[p].hdr <= ~rx_blk_o[p].hdr;
        2'h1: rx_blk_o[p].hdr <= prs_pkg::HDR_DATA;
        2'h2: rx_blk_o[p].hdr <= 2'h0;
        default: rx_blk_o[p].hdr <= prs_pkg::HDR_CTRL;
      endcase
      // Payload inverts each cycle, so a stale marker value comes back on every second block
      rx_blk_o[p].data <= (mode_i[p] == 2'h3) ? mark_i[p] : ~rx_blk_o[p].data;
    end
  end
endmodule

/* File: verification/prs_lane_status_test.sv */
// Self-checking bench for the receive lane sync status block
`timescale 1ns/100ps
module prs_lane_status_test;
  localparam int unsigned WAIT_N = 256;
  typedef struct {int phys; int pcs; logic [1:0] src;} prs_row_t;
  prs_row_t rows [4] = '{'{0, 1, 2'h0}, '{1, 2, 2'h1}, '{2, 3, 2'h2}, '{3, 0, 2'h3}};
  logic [3:0][63:0] lmark = {64'h3c5a_0f96_11e2_7d40, 64'h5a3c_96f0_e211_407d,
    64'h0f96_3c5a_7d40_11e2, 64'h96f0_5a3c_407d_e211};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0][1:0] mode = '0;
  logic [3:0][63:0] mark = '0;
  prs_pkg::prs_blk_t [3:0] rx_blk;
  logic [3:0] lock, fvalid, demux, synced, serr, exp;
  logic [3:0][2:0] ferr;
  logic [3:0][1:0] src;
  int sum [4] = '{default: 0};
  int bad_count = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  prs_far_pcs u_prs_far_pcs (.clk_i(clk_i), .mode_i(mode), .mark_i(mark), .rx_blk_o(rx_blk));

  prs_lane_status #(.MARKER_WAIT(WAIT_N)) u_prs_lane_status (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .rx_blk_i(rx_blk),
    .lane0_marker_value_i(lmark[0]), .lane1_marker_value_i(lmark[1]),
    .lane2_marker_value_i(lmark[2]), .lane3_marker_value_i(lmark[3]),
    .block_lock_o(lock), .framing_err_valid_o(fvalid), .framing_err_o(ferr),
    .lane_demux_done_o(demux), .lane0_physical_source_o(src[0]),
    .lane1_physical_source_o(src[1]), .lane2_physical_source_o(src[2]),
    .lane3_physical_source_o(src[3]), .synced_o(synced), .synced_err_o(serr));

  // Counts are only added up in cycles where their qualifier is set
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (fvalid[i] === 1'b1) sum[i] += int'(ferr[i]);
    end
  end

  task automatic chk_vec(input logic [3:0] got, input logic [3:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: vector %b expected %b", $time, got, want);
    end
  endtask

  task automatic chk_num(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: number %0d expected %0d", $time, got, want);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog at 2000 cycles, about four times the 476 cycles of planned traffic
  initial begin
    #80000;
    bad_count++;
    test_done();
  end

  initial begin
    exp = '0;
    // Marker values stay fixed from time zero, so they never move outside reset
    cycles(11);
    chk_vec(lock | synced | demux | serr | fvalid, 4'h0);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    mode <= {2'h1, 2'h1, 2'h1, 2'h2};
    cycles(5);
    mode <= {4{2'h1}};
    cycles(59);
    chk_vec(lock, 4'h0);
    cycles(1);
    chk_vec(lock, 4'he);
    cycles(5);
    chk_vec(lock, 4'hf);
    chk_num(8'(sum[0]), 8'h05);
    // Physical lane p carries PCS lane (p+1) mod 4, so source codes differ from indices
    foreach (rows[r]) begin
      mode[rows[r].phys] <= 2'h3;
      mark[rows[r].phys] <= lmark[rows[r].pcs];
      cycles(1);
      mode <= {4{2'h1}};
      cycles(3);
      exp[rows[r].pcs] = 1'b1;
      chk_vec(demux, exp);
      chk_vec(synced, exp);
      chk_num(8'(src[rows[r].pcs]), {6'h0, rows[r].src});
    end
    mode[2] <= 2'h2;
    cycles(16);
    mode <= {4{2'h1}};
    cycles(3);
    chk_vec(lock, 4'hb);
    chk_vec(synced, 4'h7);
    chk_vec(demux, 4'h7);
    chk_vec(serr, 4'h8);
    cycles(10);
    chk_num(8'(sum[2]), 8'h10);
    chk_num(8'(sum[1] + sum[3]), 8'h00);
    // Reset in mid-run, then lock every lane with no markers: all time out
    rst_b_i <= 1'b0;
    cycles(2);
    chk_vec(lock | synced | demux | serr | fvalid, 4'h0);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    cycles(WAIT_N + 90);
    chk_vec(lock, 4'hf);
    chk_vec(synced | demux, 4'h0);
    chk_vec(serr, 4'hf);
    test_done();
  end
endmodule
